// file: pkg/adcc_defines.svh
/*
  Timing counts, field codes and reset values of the converter control block.
  Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

`define ADCC_CLK_PERIOD_NS   10
`define ADCC_INSTR_CYCLE_NS  40
`define ADCC_INSTR_CYCLES    ((`ADCC_INSTR_CYCLE_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_CONV_TADS       11
`define ADCC_LAST_TAD        4'hA
`define ADCC_CLKSEL_DIV64    3'h5
`define ADCC_DIV_MAX         6'h3F
`define ADCC_RESULT_RST      10'h000
`define ADCC_SAR_RST         10'h000
`define ADCC_JUSTIFY_PAD     6'h00

`endif

// file: pkg/adcc_pkg.sv
/*
  Types of the converter control block: state codes and the configuration carrier.
  Assumes nothing of its surroundings.
*/
package adcc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV  = 2'b11,
    ST_ABORT = 2'b10
  } adcc_state_t;

  // reference_select: bit 1 positive ref external, bit 0 negative ref external
  typedef struct packed {
    logic [2:0] channel_select;
    logic [1:0] reference_select;
    logic [2:0] conv_clock_select;
    logic       result_justify_select;
    logic       converter_power_on;
  } adcc_cfg_t;

endpackage : adcc_pkg

// file: tb/adcc_analog_model.sv
/*
  Analog side model: comparator on the trial code, dedicated oscillator.
  Assumes the trial code is registered on sys_clk_i; vin_i held per conversion.
*/
`timescale 1ns/10ps

module adcc_analog_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  // analog side
  input  wire logic [9:0] vin_i,
  input  wire logic [9:0] dac_code_i,
  output logic            cmp_o,
  output logic            frc_clk_o
);
  // free running, phase unrelated to sys_clk_i
  initial begin
    frc_clk_o = 1'b0;
    forever #23 frc_clk_o = ~frc_clk_o;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) cmp_o <= 1'b0;
    else cmp_o <= (vin_i >= dac_code_i);
  end
endmodule : adcc_analog_model

// file: tb/testbench.sv
/*
  Self-checking bench of the converter control block.
  Assumes the analog model answers on sys_clk_i at 100 MHz.
*/
`timescale 1ns/10ps
`define CYC @(posedge sys_clk_i)
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end

module testbench;
  logic                sys_clk_i, resetn_i, clk_en_i, go_set_i, go_clear_i, cmp_i;
  logic                irq_enable_i, irq_flag_clear_i, sleep_i, trig_i, frc_clk_i, w;
  adcc_pkg::adcc_cfg_t cfg_i;
  logic [9:0]          vin, dac_code_o;
  logic [2:0]          sh_channel_o;
  logic [7:0]          result_high_byte_o, result_low_byte_o;
  logic [15:0]         res;
  logic                ref_pos_ext_o, ref_neg_ext_o, analog_power_o, sample_o, go_done_o;
  logic                converter_irq_flag_o, wake_o, timer_reset_o;
  int                  num_errors = 0, n_tests = 0, n;

  assign res = {result_high_byte_o, result_low_byte_o};
  adcc_top uut (.sys_clk_i, .resetn_i, .clk_en_i, .cfg_i, .go_set_i, .go_clear_i,
    .irq_enable_i, .irq_flag_clear_i, .sleep_i, .trig_i, .cmp_i, .frc_clk_i, .sh_channel_o,
    .ref_pos_ext_o, .ref_neg_ext_o, .analog_power_o, .sample_o, .dac_code_o, .go_done_o,
    .converter_irq_flag_o, .result_high_byte_o, .result_low_byte_o, .wake_o, .timer_reset_o);
  adcc_analog_model analog (.sys_clk_i, .resetn_i, .vin_i(vin), .dac_code_i(dac_code_o),
    .cmp_o(cmp_i), .frc_clk_o(frc_clk_i));

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // start, then count edges until go/done falls; optional rewrite, abort, sleep
  task automatic go(input logic trig, input int rep, input int ab, input int slp);
    `CYC;
    if (trig) trig_i <= 1'b1;
    else go_set_i <= 1'b1;
    `CYC;
    trig_i   <= 1'b0;
    go_set_i <= 1'b0;
    #1;
    `CHK(timer_reset_o, trig)
    n = 0;
    w = 1'b0;
    do begin
      `CYC;
      go_set_i   <= (n == rep);
      go_clear_i <= (n == ab);
      if (n == slp) sleep_i <= 1'b1;
      #1;
      n++;
      w |= wake_o;
      if (n == 1) begin
        `CHK(go_done_o, 1'b1)
        `CHK(sample_o, cfg_i.conv_clock_select[2] & cfg_i.conv_clock_select[1])
        `CHK(dac_code_o, 10'h000)
      end
    end while (go_done_o === 1'b1 && n < 4000);
  endtask : go

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #100us;
    num_errors++;
    results();
  end

  initial begin
    {resetn_i, go_set_i, go_clear_i, irq_enable_i, irq_flag_clear_i, sleep_i, trig_i} = '0;
    clk_en_i = 1'b1;
    cfg_i    = '0;
    vin      = 10'h2A5;
    repeat (5) `CYC;
    #1;
    `CHK({go_done_o, converter_irq_flag_o, analog_power_o, res}, 19'h00000)
    `CYC;
    resetn_i <= 1'b1;
    cfg_i    <= '{3'h5, 2'h2, 3'h0, 1'b0, 1'b1};
    // power first, acquire, then start
    repeat (20) `CYC;
    #1;
    `CHK({sh_channel_o, ref_pos_ext_o, ref_neg_ext_o, analog_power_o, sample_o}, 7'h5B)
    for (int s = 0; s < 6; s++) begin
      `CYC;
      cfg_i.conv_clock_select <= s[2:0];
      vin                     <= 10'h0C3 + 10'h07B * s[9:0];
      go(1'b0, -1, -1, -1);
      `CHK(n, 11 * (2 << s))
      `CHK({converter_irq_flag_o, res}, {1'b1, 6'h00, vin})
      `CYC;
      irq_flag_clear_i <= 1'b1;
      `CYC;
      irq_flag_clear_i <= 1'b0;
      cfg_i.result_justify_select <= 1'b1;
      repeat (3) `CYC;
      #1;
      `CHK(res, {vin, 6'h00})
      `CHK(converter_irq_flag_o, 1'b0)
      cfg_i.result_justify_select <= 1'b0;
    end
    `CYC;
    cfg_i.conv_clock_select <= 3'h0;
    vin                     <= 10'h3FF;
    go(1'b1, 10, -1, -1);
    `CHK(n, 22)
    `CHK(res, 16'h03FF)
    `CYC;
    cfg_i.conv_clock_select <= 3'h1;
    vin                     <= 10'h001;
    go(1'b0, -1, 8, -1);
    `CHK({sample_o, res}, 17'h003FF)
    go_set_i <= 1'b1;
    `CYC;
    go_set_i <= 1'b0;
    repeat (3) `CYC;
    #1;
    `CHK({go_done_o, sample_o}, 2'b00)
    repeat (8) `CYC;
    #1;
    `CHK(sample_o, 1'b1)
    cfg_i.converter_power_on <= 1'b0;
    go_set_i                 <= 1'b1;
    `CYC;
    go_set_i <= 1'b0;
    repeat (2) `CYC;
    #1;
    `CHK({go_done_o, analog_power_o}, 2'b00)
    cfg_i.converter_power_on <= 1'b1;
    repeat (20) `CYC;
    go(1'b0, -1, -1, 6);
    `CHK({analog_power_o, res}, 17'h003FF)
    sleep_i                 <= 1'b0;
    cfg_i.conv_clock_select <= 3'h6;
    irq_enable_i            <= 1'b1;
    vin                     <= 10'h155;
    repeat (20) `CYC;
    go(1'b0, -1, -1, 0);
    `CHK({w, res}, 17'h10155)
    sleep_i      <= 1'b0;
    irq_enable_i <= 1'b0;
    vin          <= 10'h2AA;
    repeat (20) `CYC;
    go(1'b0, -1, -1, 0);
    repeat (2) `CYC;
    #1;
    `CHK({w, analog_power_o, res}, 18'h002AA)
    sleep_i                 <= 1'b0;
    cfg_i.conv_clock_select <= 3'h5;
    repeat (20) `CYC;
    go_set_i <= 1'b1;
    `CYC;
    go_set_i <= 1'b0;
    repeat (30) `CYC;
    resetn_i <= 1'b0;
    #1;
    `CHK({go_done_o, converter_irq_flag_o, analog_power_o, res}, 19'h00000)
    results();
  end
endmodule : testbench

// file: verilog/adcc_top.sv
/*
  Conversion control of a 10-bit successive-approximation converter.
  Assumes the analog core registers its comparator output on sys_clk_i, the
  capture/compare trigger and sleep come from sys_clk_i logic, and the
  dedicated oscillator arrives as a free-running asynchronous input.
*/
`timescale 1ns/10ps
`include "adcc_defines.svh"

module adcc_top (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              clk_en_i,
  // configuration bits
  input  wire adcc_pkg::adcc_cfg_t cfg_i,
  // go/done and flag control
  input  wire logic              go_set_i,
  input  wire logic              go_clear_i,
  input  wire logic              irq_enable_i,
  input  wire logic              irq_flag_clear_i,
  input  wire logic              sleep_i,
  // capture/compare trigger
  input  wire logic              trig_i,
  // analog core
  input  wire logic              cmp_i,
  input  wire logic              frc_clk_i,
  output logic [2:0]             sh_channel_o,
  output logic                   ref_pos_ext_o,
  output logic                   ref_neg_ext_o,
  output logic                   analog_power_o,
  output logic                   sample_o,
  output logic [9:0]             dac_code_o,
  // status and result
  output logic                   go_done_o,
  output logic                   converter_irq_flag_o,
  output logic [7:0]             result_high_byte_o,
  output logic [7:0]             result_low_byte_o,
  output logic                   wake_o,
  output logic                   timer_reset_o
);

  adcc_pkg::adcc_state_t st_r;
  adcc_pkg::adcc_state_t st_nxt;
  logic        frc_s1_r, frc_s2_r, frc_s3_r;
  logic [5:0]  div_cnt_r;
  logic [3:0]  bit_idx_r;
  logic [2:0]  delay_cnt_r;
  logic        abort_cnt_r;
  logic [9:0]  sar_r;
  logic [9:0]  result_r;
  logic        sleep_off_r;
  logic [9:0]  sar_nxt;

  wire         frc_sel      = cfg_i.conv_clock_select > `ADCC_CLKSEL_DIV64;
  wire [2:0]   div_shift    = `ADCC_CLKSEL_DIV64 - cfg_i.conv_clock_select;
  wire [5:0]   div_last     = `ADCC_DIV_MAX >> div_shift;
  wire         frc_edge     = frc_s2_r & ~frc_s3_r;
  wire         in_conv      = (st_r == adcc_pkg::ST_CONV);
  wire         in_delay     = (st_r == adcc_pkg::ST_DELAY);
  wire         in_abort     = (st_r == adcc_pkg::ST_ABORT);
  wire         running      = in_conv | in_delay;
  wire         tad_tick     = frc_sel ? frc_edge : (div_cnt_r == div_last);
  wire         start_req    = (go_set_i | trig_i) & cfg_i.converter_power_on
                              & (st_r == adcc_pkg::ST_IDLE);
  wire         sleep_kill   = sleep_i & ~frc_sel;
  wire         abort_req    = running & (go_clear_i | ~cfg_i.converter_power_on | sleep_kill);
  wire         delay_done   = in_delay & (delay_cnt_r == 3'(`ADCC_INSTR_CYCLES - 1));
  wire         complete     = in_conv & tad_tick & (bit_idx_r == `ADCC_LAST_TAD);
  wire         abort_done   = in_abort & tad_tick & abort_cnt_r;
  wire [3:0]   bit_pos      = `ADCC_LAST_TAD - bit_idx_r;
  wire         sleep_off_nxt = sleep_i & (sleep_off_r | ~frc_sel | (complete & ~irq_enable_i));
  wire         go_nxt       = start_req | ((in_conv | in_delay) & ~(complete | abort_req));
  wire         irq_nxt      = complete | (converter_irq_flag_o & ~irq_flag_clear_i);
  wire [9:0]   result_nxt   = complete ? sar_nxt : result_r;
  wire [15:0]  justified    = cfg_i.result_justify_select ? {result_nxt, `ADCC_JUSTIFY_PAD}
                                                          : {`ADCC_JUSTIFY_PAD, result_nxt};
  wire         sample_nxt   = cfg_i.converter_power_on & ~sleep_off_nxt
                              & ((st_nxt == adcc_pkg::ST_IDLE) | (st_nxt == adcc_pkg::ST_DELAY));

  // one trial step per bit: decide current bit, raise the next lower one
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_sar
      assign sar_nxt[gi] = (bit_idx_r == 4'h0)          ? (gi == 9) :
                           (bit_pos == 4'(gi))           ? cmp_i :
                           (bit_pos == 4'(gi + 1))       ? 1'b1 : sar_r[gi];
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      adcc_pkg::ST_IDLE: begin
        if (start_req) begin
          st_nxt = frc_sel ? adcc_pkg::ST_DELAY : adcc_pkg::ST_CONV;
        end
      end
      adcc_pkg::ST_DELAY: begin
        if (abort_req) begin
          st_nxt = adcc_pkg::ST_ABORT;
        end else if (delay_done) begin
          st_nxt = adcc_pkg::ST_CONV;
        end
      end
      adcc_pkg::ST_CONV: begin
        if (abort_req) begin
          st_nxt = adcc_pkg::ST_ABORT;
        end else if (complete) begin
          st_nxt = adcc_pkg::ST_IDLE;
        end
      end
      adcc_pkg::ST_ABORT: begin
        if (abort_done) begin
          st_nxt = adcc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // oscillator edge detect behind a two-stage synchroniser
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frc_s1_r <= 1'b0;
      frc_s2_r <= 1'b0;
      frc_s3_r <= 1'b0;
    end else if (clk_en_i) begin
      frc_s1_r <= frc_clk_i;
      frc_s2_r <= frc_s1_r;
      frc_s3_r <= frc_s2_r;
    end
  end

  // sequencing counters; divider restarts on abort so the wait is whole periods
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r        <= adcc_pkg::ST_IDLE;
      div_cnt_r   <= 6'h00;
      bit_idx_r   <= 4'h0;
      delay_cnt_r <= 3'h0;
      abort_cnt_r <= 1'b0;
      sar_r       <= `ADCC_SAR_RST;
    end else if (clk_en_i) begin
      st_r        <= st_nxt;
      div_cnt_r   <= (!(in_conv | in_abort) | tad_tick | abort_req) ? 6'h00 : div_cnt_r + 6'h01;
      bit_idx_r   <= !in_conv ? 4'h0 : (tad_tick ? bit_idx_r + 4'h1 : bit_idx_r);
      delay_cnt_r <= in_delay ? delay_cnt_r + 3'h1 : 3'h0;
      abort_cnt_r <= in_abort & (abort_cnt_r ^ tad_tick);
      sar_r       <= start_req ? `ADCC_SAR_RST : ((in_conv & tad_tick) ? sar_nxt : sar_r);
    end
  end

  // status, result and analog-facing outputs
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_r             <= `ADCC_RESULT_RST;
      sleep_off_r          <= 1'b0;
      go_done_o            <= 1'b0;
      converter_irq_flag_o <= 1'b0;
      result_high_byte_o   <= 8'h00;
      result_low_byte_o    <= 8'h00;
      sh_channel_o         <= 3'h0;
      ref_pos_ext_o        <= 1'b0;
      ref_neg_ext_o        <= 1'b0;
      analog_power_o       <= 1'b0;
      sample_o             <= 1'b0;
      dac_code_o           <= `ADCC_SAR_RST;
      wake_o               <= 1'b0;
      timer_reset_o        <= 1'b0;
    end else if (clk_en_i) begin
      result_r             <= result_nxt;
      sleep_off_r          <= sleep_off_nxt;
      go_done_o            <= go_nxt;
      converter_irq_flag_o <= irq_nxt;
      result_high_byte_o   <= justified[15:8];
      result_low_byte_o    <= justified[7:0];
      sh_channel_o         <= cfg_i.channel_select;
      ref_pos_ext_o        <= cfg_i.reference_select[1];
      ref_neg_ext_o        <= cfg_i.reference_select[0];
      analog_power_o       <= cfg_i.converter_power_on & ~sleep_off_nxt;
      sample_o             <= sample_nxt;
      dac_code_o           <= (in_conv & tad_tick) ? sar_nxt : sar_r;
      wake_o               <= complete & sleep_i & irq_enable_i;
      timer_reset_o        <= trig_i;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i || !clk_en_i);

  sequence s_done;
    !go_done_o && converter_irq_flag_o;
  endsequence
  sequence s_abort_wait;
    in_abort [*3];
  endsequence

  property p_channel;
    ##1 sh_channel_o == $past(cfg_i.channel_select);
  endproperty
  a_channel: assert property (p_channel) else $error("channel not routed");

  property p_ref;
    ##1 {ref_pos_ext_o, ref_neg_ext_o} == $past(cfg_i.reference_select);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");

  property p_complete;
    complete |=> s_done ##0 (result_r == $past(sar_nxt));
  endproperty
  a_complete: assert property (p_complete) else $error("completion effects missing");

  property p_conv_len;
    complete |-> (bit_idx_r == `ADCC_LAST_TAD) && in_conv && $past(in_conv);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_abort_keep;
    abort_req && in_conv |=> $stable(result_r) [*3];
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("result changed on abort");

  property p_abort_wait;
    abort_req |=> s_abort_wait;
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort wait too short");

  property p_frc_delay;
    in_conv && $past(in_delay) |-> $past(delay_cnt_r) == 3'h3;
  endproperty
  a_frc_delay: assert property (p_frc_delay) else $error("oscillator start delay wrong");

  property p_power;
    !cfg_i.converter_power_on |=> !analog_power_o;
  endproperty
  a_power: assert property (p_power) else $error("powered while off");

  property p_sleep_abort;
    sleep_i && !frc_sel && in_conv |=> in_abort && !go_done_o ##1 !analog_power_o || !sleep_i;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

  property p_go_hold;
    in_conv && !$past(abort_req) |-> go_done_o;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("go low while converting");

  property p_trigger;
    trig_i && cfg_i.converter_power_on && st_r == adcc_pkg::ST_IDLE |=> timer_reset_o && go_done_o;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger not honoured");

  property p_justify;
    ##1 ($past(cfg_i.result_justify_select) ? result_low_byte_o[5:0] == 6'h00
                                            : result_high_byte_o[7:2] == 6'h00);
  endproperty
  a_justify: assert property (p_justify) else $error("padding bits not zero");

endmodule : adcc_top
